// *** event_router_pkg.sv ***
package event_router_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CHANNEL_LEVEL = 8'h08;
  localparam logic [7:0] IDX_CHANNEL_BASE  = 8'h10;
  localparam logic [7:0] IDX_USER_BASE     = 8'h20;
  localparam logic [7:0] SEL_RESET         = 8'h00;

  // ----------------------------------------------------------------
  // Generator codes
  // ----------------------------------------------------------------
  localparam logic [7:0] GEN_SERIAL_PERIPH_IF0_SCK      = 8'h68;
  localparam logic [7:0] GEN_SPI1_SCK      = 8'h69;
  localparam logic [7:0] GEN_TIMER_A_INST0_OVF      = 8'h80;
  localparam logic [7:0] GEN_TIMER_A_INST0_HIGH_BYTE_UNDERFLOW     = 8'h81;
  localparam logic [7:0] GEN_TIMER_A_INST0_CMP0     = 8'h84;
  localparam logic [7:0] GEN_TIMER_A_INST1_OVF      = 8'h88;
  localparam logic [7:0] GEN_TIMER_A_INST1_HIGH_BYTE_UNDERFLOW     = 8'h89;
  localparam logic [7:0] GEN_TIMER_A_INST1_CMP0     = 8'h8c;
  localparam logic [7:0] GEN_TCB_FIRST     = 8'ha0;
  localparam logic [7:0] GEN_TCB_LAST      = 8'ha9;
  localparam logic [7:0] GEN_PORT_FIRST    = 8'h40;
  localparam logic [7:0] GEN_PORT_LAST     = 8'h4f;

  // ----------------------------------------------------------------
  // User numbers
  // ----------------------------------------------------------------
  localparam int USER_LUT_FIRST   = 'h00;
  localparam int USER_ADC_START   = 'h0c;
  localparam int USER_PTC_START   = 'h0d;
  localparam int USER_EVOUT_FIRST = 'h0e;
  localparam int USER_IR_FIRST    = 'h15;
  localparam int USER_TCA_FIRST   = 'h1b;
  localparam int USER_TCB_FIRST   = 'h1f;
  localparam int USER_TCD_FIRST   = 'h29;
  localparam int NUM_USERS        = 43;

endpackage

// *** event_router.sv ***
`timescale 1ns/1ps
module event_router #(
  parameter int         NUM_CHANNELS  = 8,
  parameter bit         TIMER_A_INST1_PRESENT  = 1'b1,
  parameter logic [4:0] TCB_PRESENT   = 5'h1f,
  parameter logic [6:0] PORT_PRESENT  = 7'h7f
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Generators
  input  wire logic [1:0]  serial_periph_sck,
  input  wire logic        timer_a_inst0_overflow_or_low_underflow,
  input  wire logic        timer_a_inst0_high_byte_underflow,
  input  wire logic [2:0]  timer_a_inst0_compare_match,
  input  wire logic        timer_a_inst1_overflow_or_low_underflow,
  input  wire logic        timer_a_inst1_high_byte_underflow,
  input  wire logic [2:0]  timer_a_inst1_compare_match,
  input  wire logic [4:0]  timer_b_capture_event,
  input  wire logic [4:0]  timer_b_counter_overflow,
  input  wire logic [55:0] port_pin_level,
  input  wire logic [55:0] port_pin_input_enable,
  // Users
  output logic [11:0]      logic_table_input,
  output logic [1:0]       converter_start,
  output logic [6:0]       event_pin_out,
  output logic [5:0]       serial_unit_ir_input,
  output logic [1:0]       timer_a_count_input,
  output logic [1:0]       timer_a_restart_input,
  output logic [4:0]       timer_b_capture_input,
  output logic [4:0]       timer_b_count_input,
  output logic [1:0]       timer_d_input
);
  import event_router_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]              channel_generator_select [NUM_CHANNELS];
  logic [7:0]              event_user_channel_select [NUM_USERS];
  logic [NUM_CHANNELS-1:0] channel_level;
  logic [NUM_USERS-1:0]    user_event;
  logic [NUM_CHANNELS-1:0] next_channel_level;
  logic [NUM_USERS-1:0]    next_user_event;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire       access     = psel & penable;
  wire       commit     = access & pready;
  wire [7:0] reg_index  = paddr[9:2];
  wire [7:0] chan_off   = reg_index - IDX_CHANNEL_BASE;
  wire [7:0] user_off   = reg_index - IDX_USER_BASE;
  wire       hit_level  = (paddr[11:10] == 2'b00) && (reg_index == IDX_CHANNEL_LEVEL);
  wire       hit_chan   = (paddr[11:10] == 2'b00) && (reg_index >= IDX_CHANNEL_BASE)
                          && (chan_off < 8'(NUM_CHANNELS));
  wire       hit_user   = (paddr[11:10] == 2'b00) && (reg_index >= IDX_USER_BASE)
                          && (user_off < 8'(NUM_USERS));
  wire       hit_any    = hit_level | hit_chan | hit_user;
  wire [7:0] chan_rd    = hit_chan ? channel_generator_select[chan_off[2:0]] : 8'h00;
  wire [7:0] user_rd    = hit_user ? event_user_channel_select[user_off[5:0]] : 8'h00;
  wire [31:0] read_word = hit_level ? 32'(channel_level) :
                          hit_chan  ? {24'h000000, chan_rd} :
                          hit_user  ? {24'h000000, user_rd} : 32'h00000000;

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~hit_any;
      prdata  <= (access & ~pready & ~pwrite) ? read_word : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Channel generator select and decode
  // ----------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < NUM_CHANNELS; c++) begin : g_chan
      wire [7:0] code      = channel_generator_select[c];
      wire [7:0] tcb_off   = code - GEN_TCB_FIRST;
      wire [2:0] tcb_idx   = tcb_off[3:1];
      wire [2:0] port_idx  = 3'(((c / 2) * 2) % 8) + {2'b00, code[3]};
      wire [5:0] pin_idx   = {port_idx, code[2:0]};
      wire       port_ok   = (port_idx < 3'd7) && PORT_PRESENT[port_idx];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          channel_generator_select[c] <= SEL_RESET;
        end else if (commit && pwrite && hit_chan && chan_off == 8'(c)) begin
          channel_generator_select[c] <= pwdata[7:0];
        end
      end

      always_comb begin
        next_channel_level[c] = 1'b0;
        if (code == GEN_SERIAL_PERIPH_IF0_SCK || code == GEN_SPI1_SCK) begin
          next_channel_level[c] = serial_periph_sck[code[0]];
        end else if (code == GEN_TIMER_A_INST0_OVF) begin
          next_channel_level[c] = timer_a_inst0_overflow_or_low_underflow;
        end else if (code == GEN_TIMER_A_INST0_HIGH_BYTE_UNDERFLOW) begin
          next_channel_level[c] = timer_a_inst0_high_byte_underflow;
        end else if (code >= GEN_TIMER_A_INST0_CMP0 && code <= GEN_TIMER_A_INST0_CMP0 + 8'h02) begin
          next_channel_level[c] = timer_a_inst0_compare_match[code[1:0]];
        end else if (code == GEN_TIMER_A_INST1_OVF) begin
          next_channel_level[c] = TIMER_A_INST1_PRESENT & timer_a_inst1_overflow_or_low_underflow;
        end else if (code == GEN_TIMER_A_INST1_HIGH_BYTE_UNDERFLOW) begin
          next_channel_level[c] = TIMER_A_INST1_PRESENT & timer_a_inst1_high_byte_underflow;
        end else if (code >= GEN_TIMER_A_INST1_CMP0 && code <= GEN_TIMER_A_INST1_CMP0 + 8'h02) begin
          next_channel_level[c] = TIMER_A_INST1_PRESENT & timer_a_inst1_compare_match[code[1:0]];
        end else if (code >= GEN_TCB_FIRST && code <= GEN_TCB_LAST) begin
          next_channel_level[c] = TCB_PRESENT[tcb_idx] & (code[0] ?
                                  timer_b_counter_overflow[tcb_idx] :
                                  timer_b_capture_event[tcb_idx]);
        end else if (code >= GEN_PORT_FIRST && code <= GEN_PORT_LAST) begin
          next_channel_level[c] = port_ok & port_pin_level[pin_idx]
                                  & port_pin_input_enable[pin_idx];
        end else begin
          next_channel_level[c] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_level <= '0;
    end else begin
      channel_level <= next_channel_level;
    end
  end

  // ----------------------------------------------------------------
  // User channel select and routing
  // ----------------------------------------------------------------
  genvar u;
  generate
    for (u = 0; u < NUM_USERS; u++) begin : g_user
      wire [7:0] sel       = event_user_channel_select[u];
      wire [7:0] chan_num  = sel - 8'h01;
      wire       connected = (sel != 8'h00) && (chan_num < 8'(NUM_CHANNELS));

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          event_user_channel_select[u] <= SEL_RESET;
        end else if (commit && pwrite && hit_user && user_off == 8'(u)) begin
          event_user_channel_select[u] <= pwdata[7:0];
        end
      end

      assign next_user_event[u] = connected & channel_level[chan_num[2:0]];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_event <= '0;
    end else begin
      user_event <= next_user_event;
    end
  end

  // ----------------------------------------------------------------
  // User outputs
  // ----------------------------------------------------------------
  assign logic_table_input     = user_event[USER_LUT_FIRST +: 12];
  assign converter_start       = user_event[USER_ADC_START +: 2];
  assign event_pin_out         = user_event[USER_EVOUT_FIRST +: 7];
  assign serial_unit_ir_input  = user_event[USER_IR_FIRST +: 6];
  assign timer_a_count_input   = {user_event[USER_TCA_FIRST + 2],
                                  user_event[USER_TCA_FIRST]};
  assign timer_a_restart_input = {user_event[USER_TCA_FIRST + 3],
                                  user_event[USER_TCA_FIRST + 1]};

  genvar b;
  generate
    for (b = 0; b < 5; b++) begin : g_tcb
      assign timer_b_capture_input[b] = user_event[USER_TCB_FIRST + 2 * b];
      assign timer_b_count_input[b]   = user_event[USER_TCB_FIRST + 2 * b + 1];
    end
  endgenerate

  assign timer_d_input = user_event[USER_TCD_FIRST +: 2];

endmodule

// *** event_router_asserts.sv ***
`timescale 1ns/1ps
module event_router_asserts (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Users
  input wire logic [11:0] logic_table_input
);
  // ----------------------------------------------------------------
  // Bus and register checks
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_wait; psel && $rose(penable) |-> !pready ##1 (pready && penable); endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready not in second access cycle");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready longer than one cycle");
  property p_ready_req; pready |-> psel && penable; endproperty
  a_ready_req: assert property (p_ready_req) else $error("pready without access");
  property p_err_idx; pready && (paddr[11:10] != 2'h0 || paddr[9:2] < 8'h08) |-> pslverr; endproperty
  a_err_idx: assert property (p_err_idx) else $error("unmapped access not refused");
  property p_ok_user;
    pready && paddr[11:10] == 2'h0 && paddr[9:2] inside {[8'h20:8'h4a]} |-> !pslverr;
  endproperty
  a_ok_user: assert property (p_ok_user) else $error("user select refused");
  property p_err_data; pready && pslverr |-> prdata == 32'h0; endproperty
  a_err_data: assert property (p_err_data) else $error("refused read returned data");
  property p_idle_data; !pready |-> prdata == 32'h0; endproperty
  a_idle_data: assert property (p_idle_data) else $error("read data outside answer");
  property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  property p_reset_out; $rose(presetn) |-> logic_table_input == 12'h0; endproperty
  a_reset_out: assert property (p_reset_out) else $error("user output active after reset");
endmodule

bind event_router event_router_asserts event_router_asserts_i (.pclk, .presetn, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .logic_table_input);

// *** event_gen_model.sv ***
`timescale 1ns/1ps
module event_gen_model (
  // Source choice
  input wire logic [4:0] src,
  input wire logic       act,
  input wire logic       all,
  input wire logic       pin_en,
  // Generators
  output logic [1:0]  serial_periph_sck,
  output logic        a0_ovf, a0_high_byte_underflow, a1_ovf, a1_high_byte_underflow,
  output logic [2:0]  a0_cmp, a1_cmp,
  output logic [4:0]  b_capture_event, b_ovf,
  output logic [55:0] pin_level, pin_enable
);
  // ----------------------------------------------------------------
  // One of the 22 timer and clock sources high in code order, or all of them; every pin level high with act or all
  // ----------------------------------------------------------------
  logic [21:0] v;
  assign v = all ? 22'h3fffff : (act ? (22'h1 << src) : 22'h0);
  assign serial_periph_sck = v[1:0];
  assign a0_ovf = v[2];
  assign a0_high_byte_underflow = v[3];
  assign a0_cmp = v[6:4];
  assign a1_ovf = v[7];
  assign a1_high_byte_underflow = v[8];
  assign a1_cmp = v[11:9];
  assign b_capture_event = {v[20], v[18], v[16], v[14], v[12]};
  assign b_ovf = {v[21], v[19], v[17], v[15], v[13]};
  assign pin_level = {56{all | act}};
  assign pin_enable = {56{pin_en}};
endmodule

// *** tb_event_router.sv ***
`timescale 1ns/1ps
module tb_event_router;
  import event_router_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, act = 0, all = 0, pin_en = 0, a0o, a0h, a1o, a1h;
  logic [4:0]  src = 0, bc, bo, tbc, tbn;
  logic [2:0]  a0c, a1c;
  logic [1:0]  sck, cs, tac, tar, td;
  logic [55:0] pl, pe;
  logic [11:0] lt;
  logic [6:0]  epo;
  logic [5:0]  ir;
  int          miscompares = 0, checked = 0;
  localparam logic [7:0] UT = IDX_USER_BASE + 8'h1b;
  always #2 pclk = ~pclk;
  event_gen_model event_gen_model_i (.src, .act, .all, .pin_en, .serial_periph_sck(sck),
    .a0_ovf(a0o), .a0_high_byte_underflow(a0h), .a0_cmp(a0c), .a1_ovf(a1o), .a1_high_byte_underflow(a1h), .a1_cmp(a1c),
    .b_capture_event(bc), .b_ovf(bo), .pin_level(pl), .pin_enable(pe));
  event_router event_router_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .serial_periph_sck(sck), .timer_a_inst0_overflow_or_low_underflow(a0o),
    .timer_a_inst0_high_byte_underflow(a0h), .timer_a_inst0_compare_match(a0c),
    .timer_a_inst1_overflow_or_low_underflow(a1o), .timer_a_inst1_high_byte_underflow(a1h),
    .timer_a_inst1_compare_match(a1c), .timer_b_capture_event(bc), .timer_b_counter_overflow(bo),
    .port_pin_level(pl), .port_pin_input_enable(pe), .logic_table_input(lt), .converter_start(cs),
    .event_pin_out(epo), .serial_unit_ir_input(ir), .timer_a_count_input(tac),
    .timer_a_restart_input(tar), .timer_b_capture_input(tbc), .timer_b_count_input(tbn),
    .timer_d_input(td));
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [7:0] idx, logic [31:0] wd);
    psel <= 1; pwrite <= w; paddr <= {2'b0, idx, 2'b0}; pwdata <= wd; penable <= 0;
    @(posedge pclk) penable <= 1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic settle; repeat (3) @(posedge pclk); endtask
  function automatic logic [7:0] code(int i);
    if (i < 2) return GEN_SERIAL_PERIPH_IF0_SCK + 8'(i);
    if (i < 4) return GEN_TIMER_A_INST0_OVF + 8'(i - 2);
    if (i < 7) return GEN_TIMER_A_INST0_CMP0 + 8'(i - 4);
    if (i < 9) return GEN_TIMER_A_INST1_OVF + 8'(i - 7);
    if (i < 12) return GEN_TIMER_A_INST1_CMP0 + 8'(i - 9);
    return GEN_TCB_FIRST + 8'(i - 12);
  endfunction
  task automatic stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, UT, 0); chk("user reset", rd, 32'h0);
    apb(0, IDX_CHANNEL_BASE, 0); chk("chan reset", rd, 32'h0);
    apb(0, 8'h00, 0); chk("unmapped", {31'h0, er}, 32'h1);
    apb(1, UT, 32'hffff_ff5a); apb(0, UT, 0); chk("user rw", rd, 32'h5a);
    $display("register test done");
    apb(1, UT, 32'h1);
    for (int i = 0; i < 22; i++) begin
      apb(1, IDX_CHANNEL_BASE, {24'h0, code(i)}); src <= 5'(i); act <= 1; settle;
      chk("gen on", {31'h0, tac[0]}, 32'h1);
      act <= 0; settle; chk("gen off", {31'h0, tac[0]}, 32'h0);
    end
    $display("generator test done");
    all <= 1;
    for (int i = 0; i < 3; i++) begin
      apb(1, IDX_CHANNEL_BASE, {24'h0, 8'h83 + 8'(i * 4)}); settle;
      chk("no route", {31'h0, tac[0]}, 32'h0);
    end
    apb(1, IDX_CHANNEL_BASE, {24'h0, GEN_PORT_FIRST}); settle;
    chk("pin off", {31'h0, tac[0]}, 32'h0);
    pin_en <= 1; settle; chk("pin on", {31'h0, tac[0]}, 32'h1);
    apb(1, IDX_CHANNEL_BASE + 8'h6, {24'h0, GEN_PORT_FIRST + 8'h08});
    apb(1, UT, 32'h7); settle; chk("no port", {31'h0, tac[0]}, 32'h0);
    $display("absent test done");
    all <= 0; src <= 5'd2; act <= 1;
    apb(1, IDX_CHANNEL_BASE + 8'h1, {24'h0, GEN_TIMER_A_INST0_OVF});
    for (int u = 0; u < NUM_USERS; u++) apb(1, IDX_USER_BASE + 8'(u), 32'h2);
    settle;
    chk("lut", {20'h0, lt}, 32'hfff);
    chk("ir", {26'h0, ir}, 32'h3f);
    chk("ta", {28'h0, tar, tac}, 32'hf);
    chk("tb", {22'h0, tbn, tbc}, 32'h3ff);
    chk("misc", {21'h0, td, epo, cs}, 32'h7ff);
    apb(0, IDX_CHANNEL_LEVEL, 0); chk("level", rd, 32'h3);
    apb(1, UT, 32'h0); settle; chk("open", {31'h0, tac[0]}, 32'h0);
    apb(1, UT, 32'h9); settle; chk("beyond", {31'h0, tac[0]}, 32'h0);
    act <= 0; settle; chk("idle", {20'h0, lt}, 32'h0);
    $display("user test done");
    stop_test;
  end
endmodule
